// >>> logic/sleep_pkg.sv
// Constants for the sleep and wakeup controller
package sleep_pkg;
   // Sleep timer
   localparam int          TIMER_WIDTH     = 15;
   localparam int          SLOW_CLOCK_KHZ  = 32;
   localparam logic [7:0]  FULL_CLEAR_CODE = 8'h38;
   localparam logic [1:0]  WDT_TIMEOUT     = 2'h3;
   // Interval select: counter bit whose fall from one marks one interval
   localparam int          INTERVAL_BIT0   = 8;
   localparam int          INTERVAL_BIT1   = 10;
   localparam int          INTERVAL_BIT2   = 12;
   localparam int          INTERVAL_BIT3   = 14;
   // Clock and wakeup timing
   localparam int          CLK_MHZ         = 10;
   localparam int          POWER_GOOD_CYC  = 3;
   localparam logic [7:0]  WAKE_TAP_RESET  = 8'h7F;
   // Tap times in microseconds
   localparam int          T0_US0 = 10;
   localparam int          T0_US1 = 14;
   localparam int          T0_US2 = 20;
   localparam int          T0_US3 = 30;
   localparam int          T1_US0 = 3;
   localparam int          T1_US1 = 4;
   localparam int          T1_US2 = 5;
   localparam int          T1_US3 = 10;
   localparam int          T2_US0 = 1;
   localparam int          T2_US1 = 2;
   localparam int          T2_US2 = 5;
   localparam int          T2_US3 = 10;
   localparam int          DELAY_WIDTH = 10;
   // Sleep entry: halt request to power-down is 2.5 CPU cycles, rounded up
   localparam int          ENTRY_IGNORE_CYC = 3;
   // Wakeup tap field positions
   localparam int          T0_LSB = 0;
   localparam int          T1_LSB = 2;
   localparam int          T2_LSB = 4;
   localparam int          DBL_BIT = 6;

   typedef enum logic [1:0] {
      MODE_STANDBY,
      MODE_I2C,
      MODE_DEEP
   } sleep_mode_t;

   typedef enum logic [2:0] {
      ST_AWAKE,
      ST_HALT,
      ST_ASLEEP,
      ST_POWER_GOOD,
      ST_TAP0,
      ST_TAP1,
      ST_TAP2
   } seq_state_t;

   function automatic logic [DELAY_WIDTH-1:0] us_cycles(input int us);
      us_cycles = DELAY_WIDTH'(us * CLK_MHZ);
   endfunction
endpackage

// >>> logic/sleep_timer.sv
// Sleep timer and watchdog counter on the slow clock tick
`timescale 1ns/1ps
`default_nettype none
module sleep_timer (
   input  wire logic        clk,            // Main clock
   input  wire logic        reset,          // Any hardware reset
   input  wire logic        slow_tick,      // One pulse per slow clock edge
   input  wire logic        run,            // Timer may advance
   input  wire logic        clear_timer,    // Clear count (code 38h)
   input  wire logic        clear_wdt,      // Clear watchdog counter
   input  wire logic [1:0]  interval_sel,   // Sleep interval select
   output logic [14:0]      count,          // Sleep timer count
   output logic             interval_event, // Interval elapsed pulse
   output logic             watchdog_expire // Watchdog timeout pulse
);
   logic [14:0] count_reg;
   logic [1:0]  wdt_reg;
   logic        sel_bit;
   logic        sel_bit_reg;
   logic        rollover;

   // ==========================================================
   // Counter
   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= 15'h0000;                           // see (RULE4)
      end else if (clear_timer) begin
         count_reg <= 15'h0000;                           // see (RULE5)
      end else if (run && slow_tick) begin
         count_reg <= count_reg + 15'h0001;               // see (RULE1)
      end
   end
   assign count = count_reg;
   assign rollover = run && slow_tick && (count_reg == 15'h7FFF);

   // ==========================================================
   // Interval tap; a bit falling from one marks a full interval
   always_comb begin
      unique case (interval_sel)
         2'h0: sel_bit = count_reg[sleep_pkg::INTERVAL_BIT0];
         2'h1: sel_bit = count_reg[sleep_pkg::INTERVAL_BIT1];
         2'h2: sel_bit = count_reg[sleep_pkg::INTERVAL_BIT2];
         2'h3: sel_bit = count_reg[sleep_pkg::INTERVAL_BIT3];
      endcase
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         sel_bit_reg <= 1'b0;
      end else begin
         sel_bit_reg <= sel_bit;
      end
   end
   assign interval_event = sel_bit_reg && !sel_bit;       // see (RULE26)

   // ==========================================================
   // Watchdog: three rollovers since last clear
   always_ff @(posedge clk) begin
      if (reset || clear_wdt) begin
         wdt_reg <= 2'h0;                                 // see (RULE6)
      end else if (rollover && wdt_reg != sleep_pkg::WDT_TIMEOUT) begin
         wdt_reg <= wdt_reg + 2'h1;                       // see (RULE23)
      end
   end
   assign watchdog_expire = rollover && !clear_wdt &&
                            (wdt_reg == sleep_pkg::WDT_TIMEOUT - 2'h1);

   AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (reset)
      clear_timer |=> count_reg == 15'h0000) // see (RULE5)
      else $error("timer not cleared");
   AST_HOLD: assert property (@(posedge clk) disable iff (reset)
      !run && !clear_timer |=> $stable(count_reg)) // see (RULE2)
      else $error("timer moved while stopped");
endmodule // sleep_timer
`default_nettype wire

// >>> logic/wake_delay.sv
// One-shot delay counter for the wakeup taps
`timescale 1ns/1ps
`default_nettype none
module wake_delay (
   input  wire logic        clk,   // Main clock
   input  wire logic        reset, // Synchronous reset
   input  wire logic        start, // Load a new delay
   input  wire logic [9:0]  cycles,// Delay length in cycles
   output logic             done   // High when delay elapsed
);
   logic [9:0] left_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         left_reg <= 10'h000;
      end else if (start) begin
         left_reg <= cycles;
      end else if (left_reg != 10'h000) begin
         left_reg <= left_reg - 10'h001;
      end
   end
   // No path from start to done: the sequencer derives start from done
   assign done = (left_reg == 10'h000);
endmodule // wake_delay
`default_nettype wire

// >>> logic/sleep_wakeup_controller.sv
// Sleep entry, wakeup sequencing, sleep timer and watchdog control
// ============================================================
// Function
// (RULE1) Sleep timer is 15-bit slow-clock counter
// (RULE2) Timer stops in deep sleep, debug stop
// (RULE3) Enabled interval interrupt, asleep or awake
// (RULE4) Any hardware reset zeroes the timer
// (RULE5) Clear code 38h also zeroes timer
// (RULE6) Any clear write resets watchdog counter
// (RULE7) Sleep bit requests standby entry
// (RULE8) Deep sleep setup then low-speed osc off
// (RULE9) Crystal select without crystal stops slow clock
// (RULE10) I2C sleep wakes on address match
// (RULE11) Standby wakes on timer, GPIO, timer0
// (RULE12) I2C sleep adds I2C wake source
// (RULE13) Deep sleep wakes on GPIO only
// (RULE14) Low-voltage during buzz wakes standby
// (RULE15) Standby watchdog wakes first, then resets
// (RULE16) Sleep bit clear starts tapped wakeup
// (RULE17) Power good lasts three slow cycles
// (RULE18) T0,T1,T2 delay taps in order
// (RULE19) Pending interrupt blocks sleep bit set
// (RULE20) Masked-global interrupts still wake device
// (RULE21) Prefetched instruction runs before service
// (RULE22) Interrupts ignored before power-down
// (RULE23) Watchdog fires after three rollovers
// (RULE24) Halt request, acknowledge, then power-down
// (RULE25) Osc disable halts timer in sleep
// (RULE26) Interval event on selected bit toggle; the code fires only when the bit falls from one
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_controller (
   input  wire logic       clk,                  // CPU clock, 10 MHz
   input  wire logic       reset,                // POR or external reset
   input  wire logic       slow_clock_tick,      // Slow osc edge pulse
   input  wire logic       crystal_tick,         // Crystal osc edge pulse
   input  wire logic       sleep_bit_write,      // Write 1 to sleep bit
   input  wire logic       cpu_stop_bit,         // CPU stop bit
   input  wire logic       debug_mode,           // Emulator in debug
   input  wire logic       wdt_clear_write,      // Clear register strobe
   input  wire logic [7:0] wdt_clear_data,       // Clear register data
   input  wire logic [1:0] sleep_interval,       // Interval select
   input  wire logic       timer_irq_enable,     // Timer irq mask bit
   input  wire logic       i2c_retention,        // I2C supply on in sleep
   input  wire logic       slow_osc_disable,     // Osc off in sleep
   input  wire logic       crystal_clock_select, // Use crystal
   input  wire logic       crystal_present_flag, // Crystal exists
   input  wire logic [7:0] wake_tap_config,      // Wakeup tap settings
   input  wire logic       irq_pending,          // Enabled irq pending
   input  wire logic       gpio_irq,             // GPIO interrupt
   input  wire logic       timer0_irq,           // Timer 0 interrupt
   input  wire logic       i2c_start,            // I2C start seen
   input  wire logic       i2c_bit_valid,        // I2C address bit strobe
   input  wire logic       i2c_bit,              // I2C address bit
   input  wire logic [7:0] i2c_own_address,      // Match address
   input  wire logic       low_voltage_detect,   // Supply below limit
   input  wire logic       buzz_active,          // Buzz interval
   input  wire logic       halt_acknowledge,     // CPU halt ack
   output logic            halt_request,         // Halt CPU
   output logic            power_down_signal,    // System power down
   output logic            sleep_bit,            // Sleep bit state
   output logic            slow_osc_running,     // Low-speed osc on
   output logic            timer_irq,            // Sleep timer irq
   output logic            i2c_irq,              // I2C address match
   output logic            wakeup_done,          // Wakeup finished pulse
   output logic            watchdog_reset_event, // System reset pulse
   output logic [14:0]     timer_count           // Sleep timer value
);
   sleep_pkg::seq_state_t   state_reg;
   sleep_pkg::sleep_mode_t  mode_reg;
   logic        sleep_reg;
   logic        halt_reg;
   logic        pd_reg;
   logic [1:0]  entry_cnt_reg;
   logic [1:0]  pg_cnt_reg;
   logic        wdr_pending_reg;
   logic        wdr_reg;
   logic        irq_reg;
   logic        i2c_irq_reg;
   logic [7:0]  i2c_shift_reg;
   logic [3:0]  i2c_cnt_reg;
   logic        osc_on;
   logic        tick;
   logic        clk_dead;
   logic        timer_run;
   logic        interval_event;
   logic        wdt_expire;
   logic        wake_src;
   logic        asleep;
   logic        dly_start;
   logic [9:0]  dly_cycles;
   logic        dly_done;
   logic        dbl;
   logic        hw_reset;

   // ============================================================
   // Slow clock selection and timer run
   assign clk_dead = crystal_clock_select && !crystal_present_flag; // see (RULE9)
   assign asleep   = pd_reg;
   assign osc_on   = !(asleep && slow_osc_disable);                // see (RULE25)
   assign tick     = osc_on && !clk_dead &&
                     (crystal_clock_select ? crystal_tick : slow_clock_tick);
   assign timer_run = osc_on && !(debug_mode && cpu_stop_bit);     // see (RULE2)
   assign hw_reset = reset || wdr_reg;                             // see (RULE4)

   sleep_timer u_timer (
      .clk             (clk),
      .reset           (hw_reset),
      .slow_tick       (tick),
      .run             (timer_run),
      .clear_timer     (wdt_clear_write &&
                        wdt_clear_data == sleep_pkg::FULL_CLEAR_CODE),
      .clear_wdt       (wdt_clear_write),
      .interval_sel    (sleep_interval),
      .count           (timer_count),
      .interval_event  (interval_event),
      .watchdog_expire (wdt_expire)
   );

   // ============================================================
   // Timer interrupt, raised whether asleep or not
   always_ff @(posedge clk) begin
      if (hw_reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= interval_event && timer_irq_enable; // see (RULE3)
      end
   end
   assign timer_irq = irq_reg;

   // ============================================================
   // I2C address collector, active only in I2C sleep
   always_ff @(posedge clk) begin
      if (hw_reset || !(asleep && mode_reg == sleep_pkg::MODE_I2C)) begin
         i2c_shift_reg <= 8'h00;
         i2c_cnt_reg   <= 4'h0;
         i2c_irq_reg   <= 1'b0;
      end else if (i2c_start) begin
         i2c_shift_reg <= 8'h00;
         i2c_cnt_reg   <= 4'h1;
         i2c_irq_reg   <= 1'b0;
      end else if (i2c_bit_valid && i2c_cnt_reg != 4'h0) begin
         i2c_shift_reg <= {i2c_shift_reg[6:0], i2c_bit};
         i2c_cnt_reg   <= (i2c_cnt_reg == 4'h8) ? 4'h0 : i2c_cnt_reg + 4'h1;
         if (i2c_cnt_reg == 4'h8) begin
            i2c_irq_reg <= {i2c_shift_reg[6:0], i2c_bit} ==
                           i2c_own_address;             // see (RULE10)
         end
      end
   end
   assign i2c_irq = i2c_irq_reg;

   // ============================================================
   // Wake source selection per mode
   always_comb begin
      unique case (mode_reg)
         sleep_pkg::MODE_STANDBY: wake_src = irq_reg || gpio_irq ||
            timer0_irq || (low_voltage_detect && buzz_active) ||
            wdr_pending_reg;                            // see (RULE11) (RULE14)
         sleep_pkg::MODE_I2C: wake_src = irq_reg || gpio_irq ||
            timer0_irq || i2c_irq_reg;                  // see (RULE12)
         sleep_pkg::MODE_DEEP: wake_src = gpio_irq;     // see (RULE13)
         default: wake_src = gpio_irq;
      endcase
   end

   // ============================================================
   // Wakeup tap lengths, doubled when asked
   assign dbl = wake_tap_config[sleep_pkg::DBL_BIT];
   always_comb begin
      dly_cycles = 10'h000;
      unique case (state_reg)
         sleep_pkg::ST_POWER_GOOD: begin
            unique case (wake_tap_config[sleep_pkg::T0_LSB +: 2])
               2'h0: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T0_US0);
               2'h1: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T0_US1);
               2'h2: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T0_US2);
               2'h3: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T0_US3);
            endcase
         end
         sleep_pkg::ST_TAP0: begin
            unique case (wake_tap_config[sleep_pkg::T1_LSB +: 2])
               2'h0: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T1_US0);
               2'h1: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T1_US1);
               2'h2: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T1_US2);
               2'h3: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T1_US3);
            endcase
         end
         default: begin
            unique case (wake_tap_config[sleep_pkg::T2_LSB +: 2])
               2'h0: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T2_US0);
               2'h1: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T2_US1);
               2'h2: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T2_US2);
               2'h3: dly_cycles = sleep_pkg::us_cycles(sleep_pkg::T2_US3);
            endcase
         end
      endcase
      if (dbl) begin
         dly_cycles = {dly_cycles[8:0], 1'b0};
      end
   end
   assign dly_start = (state_reg == sleep_pkg::ST_POWER_GOOD &&
                       pg_cnt_reg == 2'(sleep_pkg::POWER_GOOD_CYC) &&
                       slow_clock_tick) ||
                      (state_reg == sleep_pkg::ST_TAP0 && dly_done) ||
                      (state_reg == sleep_pkg::ST_TAP1 && dly_done);

   wake_delay u_delay (
      .clk    (clk),
      .reset  (hw_reset),
      .start  (dly_start),
      .cycles (dly_cycles),
      .done   (dly_done)
   );

   // ============================================================
   // Sleep sequencer
   always_ff @(posedge clk) begin
      if (hw_reset) begin
         state_reg     <= sleep_pkg::ST_AWAKE;
         sleep_reg     <= 1'b0;
         halt_reg      <= 1'b0;
         pd_reg        <= 1'b0;
         entry_cnt_reg <= 2'h0;
         pg_cnt_reg    <= 2'h0;
         mode_reg      <= sleep_pkg::MODE_STANDBY;
      end else begin
         unique case (state_reg)
            sleep_pkg::ST_AWAKE: begin
               // Pending interrupt keeps the bit clear; see (RULE19)
               if (sleep_bit_write && !irq_pending) begin
                  sleep_reg     <= 1'b1;                 // see (RULE7)
                  halt_reg      <= 1'b1;                 // see (RULE24)
                  entry_cnt_reg <= 2'h1;
                  state_reg     <= sleep_pkg::ST_HALT;
                  if (!i2c_retention && slow_osc_disable &&
                      !crystal_clock_select) begin
                     mode_reg <= sleep_pkg::MODE_DEEP;   // see (RULE8)
                  end else if (i2c_retention) begin
                     mode_reg <= sleep_pkg::MODE_I2C;
                  end else begin
                     mode_reg <= sleep_pkg::MODE_STANDBY;
                  end
               end
            end
            sleep_pkg::ST_HALT: begin
               // Wake sources ignored until power-down; see (RULE22)
               if (entry_cnt_reg != 2'(sleep_pkg::ENTRY_IGNORE_CYC)) begin
                  entry_cnt_reg <= entry_cnt_reg + 2'h1;
               end else if (halt_acknowledge) begin
                  pd_reg    <= 1'b1;                     // see (RULE24)
                  state_reg <= sleep_pkg::ST_ASLEEP;
               end
            end
            sleep_pkg::ST_ASLEEP: begin
               // Unmasked source wakes regardless of global enable
               if (wake_src) begin                       // see (RULE20)
                  sleep_reg  <= 1'b0;                    // see (RULE16)
                  pg_cnt_reg <= 2'h0;
                  state_reg  <= sleep_pkg::ST_POWER_GOOD;
               end
            end
            sleep_pkg::ST_POWER_GOOD: begin
               if (dly_start) begin
                  pd_reg    <= 1'b0;
                  state_reg <= sleep_pkg::ST_TAP0;
               end else if (slow_clock_tick) begin
                  pg_cnt_reg <= pg_cnt_reg + 2'h1;       // see (RULE17)
               end
            end
            sleep_pkg::ST_TAP0: begin
               if (dly_done) begin
                  state_reg <= sleep_pkg::ST_TAP1;       // see (RULE18)
               end
            end
            sleep_pkg::ST_TAP1: begin
               if (dly_done) begin
                  state_reg <= sleep_pkg::ST_TAP2;
               end
            end
            sleep_pkg::ST_TAP2: begin
               if (dly_done) begin
                  // CPU resumes with its prefetched instruction
                  halt_reg  <= 1'b0;                     // see (RULE21)
                  state_reg <= sleep_pkg::ST_AWAKE;
               end
            end
         endcase
      end
   end

   // ============================================================
   // Watchdog: in sleep it waits for the wakeup to finish
   always_ff @(posedge clk) begin
      if (hw_reset) begin
         wdr_pending_reg <= 1'b0;
         wdr_reg         <= 1'b0;
      end else begin
         if (wdt_expire && state_reg != sleep_pkg::ST_AWAKE) begin
            wdr_pending_reg <= 1'b1;                     // see (RULE15)
         end
         wdr_reg <= (wdt_expire && state_reg == sleep_pkg::ST_AWAKE) ||
                    (wdr_pending_reg && wakeup_done);
      end
   end

   assign wakeup_done = state_reg == sleep_pkg::ST_TAP2 && dly_done;
   assign halt_request = halt_reg;
   assign power_down_signal = pd_reg;
   assign sleep_bit = sleep_reg;
   assign slow_osc_running = osc_on;
   assign watchdog_reset_event = wdr_reg;

   AST_PENDING_BLOCKS: assert property (@(posedge clk) disable iff (hw_reset)
      state_reg == sleep_pkg::ST_AWAKE && sleep_bit_write && irq_pending
      |=> !sleep_reg) // see (RULE19)
      else $error("sleep bit set despite pending irq");
   AST_PD_AFTER_ACK: assert property (@(posedge clk) disable iff (hw_reset)
      $rose(pd_reg) |-> $past(halt_acknowledge) && halt_reg) // see (RULE24)
      else $error("power down without acknowledge");
   AST_DEEP_GPIO: assert property (@(posedge clk) disable iff (hw_reset)
      state_reg == sleep_pkg::ST_ASLEEP && mode_reg == sleep_pkg::MODE_DEEP
      && !gpio_irq |=> state_reg == sleep_pkg::ST_ASLEEP) // see (RULE13)
      else $error("deep sleep left without gpio");
   AST_IGNORE_EARLY: assert property (@(posedge clk) disable iff (hw_reset)
      $rose(halt_reg) |=> !pd_reg [*2]) // see (RULE22)
      else $error("power down too early");
   AST_WDR_AFTER_WAKE: assert property (@(posedge clk) disable iff (reset)
      wdr_reg |-> $past(state_reg) == sleep_pkg::ST_AWAKE ||
      $past(wakeup_done)) // see (RULE15)
      else $error("watchdog reset mid sleep");
   AST_DEAD_NO_TICK: assert property (@(posedge clk) disable iff (hw_reset)
      clk_dead |-> !tick) // see (RULE9)
      else $error("slow clock ran without crystal");
   COV_SLEEP: cover property (@(posedge clk) $rose(pd_reg));
   COV_WAKE: cover property (@(posedge clk) wakeup_done);
   COV_I2C: cover property (@(posedge clk) i2c_irq_reg);
endmodule // sleep_wakeup_controller
`default_nettype wire

// >>> verif/cpu_model.sv
// CPU core stand-in that answers the halt handshake
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input  wire logic clk,              // CPU clock
   input  wire logic reset,            // Synchronous reset
   input  wire logic halt_request,     // Halt from sleep logic
   output var logic  halt_acknowledge  // Answer one edge later
);
   // ============================================================
   // Handshake
   // Acknowledge follows on the next rising edge, as a real core does
   always_ff @(posedge clk) begin
      if (reset) halt_acknowledge <= 1'h0;
      else halt_acknowledge <= halt_request;
   end
endmodule // cpu_model
`default_nettype wire

// >>> verif/test_sleep_wakeup_controller.sv
// Self-checking bench for the sleep and wakeup controller
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wakeup_controller;
   logic clk, reset, slow_clock_tick, crystal_tick, sleep_bit_write;
   logic cpu_stop_bit, debug_mode, wdt_clear_write, timer_irq_enable;
   logic i2c_retention, slow_osc_disable, crystal_clock_select;
   logic crystal_present_flag, irq_pending, gpio_irq, timer0_irq;
   logic i2c_start, i2c_bit_valid, i2c_bit, low_voltage_detect;
   logic buzz_active, halt_acknowledge, halt_request, power_down_signal;
   logic sleep_bit, slow_osc_running, timer_irq, i2c_irq, wakeup_done;
   logic watchdog_reset_event, seen_done;
   logic [7:0]  wdt_clear_data, wake_tap_config, i2c_own_address;
   logic [1:0]  sleep_interval;
   logic [14:0] timer_count;
   int          err_total, n_checks;
   sleep_wakeup_controller sleep_wakeup_controller_inst (.clk, .reset,
      .slow_clock_tick, .crystal_tick, .sleep_bit_write, .cpu_stop_bit,
      .debug_mode, .wdt_clear_write, .wdt_clear_data, .sleep_interval,
      .timer_irq_enable, .i2c_retention, .slow_osc_disable,
      .crystal_clock_select, .crystal_present_flag, .wake_tap_config,
      .irq_pending, .gpio_irq, .timer0_irq, .i2c_start, .i2c_bit_valid,
      .i2c_bit, .i2c_own_address, .low_voltage_detect, .buzz_active,
      .halt_acknowledge, .halt_request, .power_down_signal, .sleep_bit,
      .slow_osc_running, .timer_irq, .i2c_irq, .wakeup_done,
      .watchdog_reset_event, .timer_count);
   cpu_model cpu_model_inst (.clk, .reset, .halt_request,
      .halt_acknowledge);
   // ============================================================
   // Clock and helpers
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // Wakeup done is a one-cycle pulse; latch it so polling cannot miss it
   always @(posedge clk) if (wakeup_done) seen_done <= 1'h1;
   task automatic chk(string what, logic [14:0] exp, logic [14:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick;
      slow_clock_tick <= 1'h1;
      @(posedge clk) slow_clock_tick <= 1'h0;
      @(posedge clk) #1;
   endtask
   task automatic wdt(logic [7:0] d);
      wdt_clear_write <= 1'h1;
      wdt_clear_data <= d;
      @(posedge clk) wdt_clear_write <= 1'h0;
      @(posedge clk) #1;
   endtask
   task automatic go_sleep;
      sleep_bit_write <= 1'h1;
      @(posedge clk) sleep_bit_write <= 1'h0;
      @(posedge clk) #1;
   endtask
   // Caller clears seen_done before the wake can start
   task automatic wait_wake;
      for (int i = 0; i < 2000 && !seen_done; i++) tick();
      chk("wakeup done", 15'h1, 15'(seen_done));
      chk("awake", 15'h0, 15'(sleep_bit));
      if (!seen_done) conclude();
   endtask
   // Start, then eight address bits, first bit sent first
   task automatic i2c_addr(logic [7:0] a);
      i2c_start <= 1'h1;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk) i2c_start <= 1'h0;
         i2c_bit_valid <= 1'h1;
         i2c_bit <= a[i];
      end
      @(posedge clk) i2c_bit_valid <= 1'h0;
      @(posedge clk) #1;
   endtask
   // ============================================================
   // Scenarios
   task automatic t_timer;
      chk("count at reset", 15'h0, timer_count);
      chk("osc running", 15'h1, 15'(slow_osc_running));
      repeat (5) tick();
      chk("count after ticks", 15'h5, timer_count);
      wdt(8'h12);
      chk("count kept", 15'h5, timer_count);
      wdt(8'h38);
      chk("count cleared", 15'h0, timer_count);
      $display("test timer done");
   endtask
   task automatic t_blocked;
      irq_pending <= 1'h1;
      go_sleep();
      chk("sleep bit blocked", 15'h0, 15'(sleep_bit));
      irq_pending <= 1'h0;
      $display("test blocked done");
   endtask
   task automatic t_irq;
      timer_irq_enable <= 1'h1;
      wdt(8'h38);
      repeat (511) tick();
      chk("irq early", 15'h0, 15'(timer_irq));
      tick();
      chk("timer irq", 15'h1, 15'(timer_irq));
      timer_irq_enable <= 1'h0;
      $display("test irq done");
   endtask
   task automatic t_i2c;
      i2c_retention <= 1'h1;
      slow_osc_disable <= 1'h0;
      seen_done <= 1'h0;
      go_sleep();
      repeat (6) @(posedge clk);
      i2c_addr(8'hA5);
      chk("i2c other address", 15'h0, 15'(i2c_irq));
      i2c_addr(8'h5A);
      chk("i2c match", 15'h1, 15'(i2c_irq));
      wait_wake();
      i2c_retention <= 1'h0;
      $display("test i2c done");
   endtask
   task automatic t_sleep(logic deep);
      slow_osc_disable <= deep;
      seen_done <= 1'h0;
      go_sleep();
      chk("sleep bit", 15'h1, 15'(sleep_bit));
      chk("halt request", 15'h1, 15'(halt_request));
      repeat (6) @(posedge clk);
      chk("power down", 15'h1, 15'(power_down_signal));
      timer0_irq <= deep;
      repeat (50) tick();
      chk("still asleep", 15'h1, 15'(power_down_signal));
      timer0_irq <= 1'h0;
      gpio_irq <= 1'h1;
      wait_wake();
      gpio_irq <= 1'h0;
      $display("test sleep done");
   endtask
   initial begin
      {slow_clock_tick, crystal_tick, sleep_bit_write, cpu_stop_bit} = '0;
      {debug_mode, wdt_clear_write, timer_irq_enable, i2c_retention} = '0;
      {slow_osc_disable, crystal_clock_select, irq_pending, gpio_irq} = '0;
      {timer0_irq, i2c_start, i2c_bit_valid, i2c_bit, buzz_active} = '0;
      {low_voltage_detect, seen_done, sleep_interval} = '0;
      {crystal_present_flag, reset} = 2'h3;
      {wdt_clear_data, err_total, n_checks} = '0;
      wake_tap_config = 8'h7F;
      i2c_own_address = 8'h5A;
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk) #1;
      t_timer();
      t_blocked();
      t_irq();
      t_sleep(1'h0);
      t_sleep(1'h1);
      t_i2c();
      conclude();
   end
endmodule // test_sleep_wakeup_controller
`default_nettype wire
